/* hw/acc_pkg.sv */
/*
  Package for the conversion result correction stage: register indices,
  reset values, field layout of the selection register and data widths.
  Assumes nothing of its surroundings.
*/
package acc_pkg;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_DEST = 8;
  localparam int unsigned SEL_W = 2;
  // Printed register offsets (word indices on the plain register port).
  localparam logic [7:0] OFF_SEL = 8'h12;
  localparam logic [7:0] OFF_SYS_OFF_A = 8'h13;
  localparam logic [7:0] OFF_SYS_OFF_B = 8'h14;
  localparam logic [7:0] OFF_SYS_GAIN_A = 8'h15;
  localparam logic [7:0] OFF_SYS_GAIN_B = 8'h16;
  localparam logic [7:0] OFF_SELF_OFF = 8'h17;
  localparam logic [7:0] OFF_SELF_GAIN = 8'h18;
  localparam logic [23:0] RST_COEF = 24'h000000;
  localparam logic [15:0] RST_SEL = 16'h0000;
  // Selection codes per destination.
  localparam logic [1:0] SEL_SET_A = 2'h0;
  localparam logic [1:0] SEL_SET_B = 2'h1;
  // Binary point of gains: top bit weighs one, 23 fraction bits.
  localparam int unsigned GAIN_FRAC = 23;
  localparam logic [23:0] POS_MAX = 24'h7fffff;
  localparam logic [23:0] NEG_MIN = 24'h800000;
  localparam logic [23:0] UNI_MAX = 24'hffffff;
  localparam logic [23:0] UNI_MIN = 24'h000000;
endpackage

/* hw/acc_gain_mul.sv */
/*
  Signed value times unsigned 1.23 fixed point gain, with saturation to
  24 bits in either two's complement or offset binary range.
  Assumes a single clock; one cycle of latency.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_gain_mul #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W:0]   in_value,
  input  wire logic [W-1:0] gain,
  input  wire logic         bypass,
  input  wire logic         unipolar,
  output logic              out_valid,
  output logic [W-1:0]      out_value
);
  logic signed [2*W+1:0] prod;
  logic signed [W+2:0]   scaled;
  logic signed [W+2:0]   src;
  logic [W-1:0]          sat_d;

  assign prod = $signed(in_value) * $signed({1'b0, gain});
  assign src = {{2{in_value[W]}}, in_value};

  always_comb begin
    // Truncation keeps the integer part of the 1.23 product.
    scaled = bypass ? src : prod[acc_pkg::GAIN_FRAC +: W+3]; // RULE7
    if (unipolar) begin
      if (scaled < 0) begin
        sat_d = acc_pkg::UNI_MIN; // RULE15
      end else if (scaled > $signed({3'b000, acc_pkg::UNI_MAX})) begin
        sat_d = acc_pkg::UNI_MAX; // RULE15
      end else begin
        sat_d = scaled[W-1:0];
      end
    end else begin
      if (scaled > $signed({3'b000, acc_pkg::POS_MAX})) begin
        sat_d = acc_pkg::POS_MAX; // RULE15
      end else if (scaled < $signed({3'b111, acc_pkg::NEG_MIN})) begin
        sat_d = acc_pkg::NEG_MIN; // RULE15
      end else begin
        sat_d = scaled[W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_value <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_value <= sat_d;
      end
    end
  end
endmodule
`default_nettype wire

/* hw/acc_correct.sv */
/*
  Conversion result correction stage: self gain, self offset, selectable
  system offset and system gain, per destination register.
  Assumes the conversion pipeline presents one raw 24-bit result with its
  destination index as a one-cycle valid pulse, and that software reaches
  the coefficients over a plain register port with one-cycle read data.
*/
// Added by the designer: the strobed register port.
//
// What this block does
// RULE1 - Set B subtracts system offset B.
// RULE2 - System offset always two's complement.
// RULE3 - System offset held until written or calibrated.
// RULE4 - System offset after self cal, before gain.
// RULE5 - Multiply by selected system gain A or B.
// RULE6 - System gain unsigned, format independent.
// RULE7 - Gain binary point below the MSB.
// RULE8 - Gain scaling reaches 1.999999881 times.
// RULE9 - System gain held until written or calibrated.
// RULE10 - Subtract self calibration offset.
// RULE11 - Self offset after self gain, before system.
// RULE12 - Self offset held until written or recalibrated.
// RULE13 - Select code 0 A, 1 B, 2/3 off.
// RULE14 - Set A subtracts system offset A.
// RULE15 - Gain product truncated and clamped to range.
// RULE16 - Disabled selection passes self-calibrated result.
`timescale 1ns/1ps
`default_nettype none
module acc_correct #(
  parameter int unsigned W     = acc_pkg::DATA_W,
  parameter int unsigned NDEST = acc_pkg::NUM_DEST
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [acc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  input  wire logic                       unipolar_bipolar_select,
  input  wire logic                       output_format_select,
  input  wire logic                       raw_valid,
  input  wire logic [W-1:0]               raw_value,
  input  wire logic [2:0]                 raw_dest,
  input  wire logic                       cal_load,
  input  wire logic [2:0]                 cal_target,
  input  wire logic [W-1:0]               cal_value,
  output logic                            result_valid,
  output logic      [W-1:0]               result_value,
  output logic      [2:0]                 result_dest
);

  ////////////////////////////////////////////////////////////////////////
  // Coefficient registers.

  logic [2*NDEST-1:0] correction_set_select_q;
  logic [W-1:0]       system_offset_first_q;
  logic [W-1:0]       system_offset_second_q;
  logic [W-1:0]       system_gain_first_q;
  logic [W-1:0]       system_gain_second_q;
  logic [W-1:0]       self_cal_offset_value_q;
  logic [W-1:0]       self_gain_value_q;

  // Calibration targets: 0 self offset, 1 offset A, 2 offset B,
  // 3 gain A, 4 gain B. A software write in the same cycle wins, since
  // it is the later intent of the program.
  logic wr_sel;
  logic wr_off_a;
  logic wr_off_b;
  logic wr_gain_a;
  logic wr_gain_b;
  logic wr_self_off;
  logic wr_self_gain;

  assign wr_sel       = reg_wr && reg_addr == acc_pkg::OFF_SEL;
  assign wr_off_a     = reg_wr && reg_addr == acc_pkg::OFF_SYS_OFF_A;
  assign wr_off_b     = reg_wr && reg_addr == acc_pkg::OFF_SYS_OFF_B;
  assign wr_gain_a    = reg_wr && reg_addr == acc_pkg::OFF_SYS_GAIN_A;
  assign wr_gain_b    = reg_wr && reg_addr == acc_pkg::OFF_SYS_GAIN_B;
  assign wr_self_off  = reg_wr && reg_addr == acc_pkg::OFF_SELF_OFF;
  assign wr_self_gain = reg_wr && reg_addr == acc_pkg::OFF_SELF_GAIN;

  always_ff @(posedge clk) begin
    if (rst) begin
      correction_set_select_q <= acc_pkg::RST_SEL;
    end else if (wr_sel) begin
      correction_set_select_q <= reg_wdata[2*NDEST-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      system_offset_first_q  <= acc_pkg::RST_COEF;
      system_offset_second_q <= acc_pkg::RST_COEF;
    end else begin
      if (wr_off_a) begin
        system_offset_first_q <= reg_wdata[W-1:0]; // RULE3
      end else if (cal_load && cal_target == 3'h1) begin
        system_offset_first_q <= cal_value; // RULE3
      end
      if (wr_off_b) begin
        system_offset_second_q <= reg_wdata[W-1:0]; // RULE3
      end else if (cal_load && cal_target == 3'h2) begin
        system_offset_second_q <= cal_value; // RULE3
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      system_gain_first_q  <= acc_pkg::RST_COEF;
      system_gain_second_q <= acc_pkg::RST_COEF;
    end else begin
      if (wr_gain_a) begin
        system_gain_first_q <= reg_wdata[W-1:0]; // RULE9
      end else if (cal_load && cal_target == 3'h3) begin
        system_gain_first_q <= cal_value; // RULE9
      end
      if (wr_gain_b) begin
        system_gain_second_q <= reg_wdata[W-1:0]; // RULE9
      end else if (cal_load && cal_target == 3'h4) begin
        system_gain_second_q <= cal_value; // RULE9
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      self_cal_offset_value_q <= acc_pkg::RST_COEF;
      self_gain_value_q       <= acc_pkg::RST_COEF;
    end else begin
      if (wr_self_off) begin
        self_cal_offset_value_q <= reg_wdata[W-1:0]; // RULE12
      end else if (cal_load && cal_target == 3'h0) begin
        self_cal_offset_value_q <= cal_value; // RULE12
      end
      if (wr_self_gain) begin
        self_gain_value_q <= reg_wdata[W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port: data stands in the cycle after the strobe only.

  logic [31:0] rdata_d;

  always_comb begin
    case (reg_addr)
      acc_pkg::OFF_SEL:        rdata_d = {16'h0000, correction_set_select_q};
      acc_pkg::OFF_SYS_OFF_A:  rdata_d = {8'h00, system_offset_first_q};
      acc_pkg::OFF_SYS_OFF_B:  rdata_d = {8'h00, system_offset_second_q};
      acc_pkg::OFF_SYS_GAIN_A: rdata_d = {8'h00, system_gain_first_q};
      acc_pkg::OFF_SYS_GAIN_B: rdata_d = {8'h00, system_gain_second_q};
      acc_pkg::OFF_SELF_OFF:   rdata_d = {8'h00, self_cal_offset_value_q};
      acc_pkg::OFF_SELF_GAIN:  rdata_d = {8'h00, self_gain_value_q};
      default:                 rdata_d = 32'h00000000;
    endcase
  end

  // Data returns to zero after its cycle, so that read data of several
  // slaves can be ORed on a shared return path.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stage 1: self-calibration gain then self offset.

  // Self gain is treated as the same unsigned 1.23 format as the system
  // gain. A zero self gain reads as unity, yet a block left at reset values
  // blanks every result, since every destination selects set A, whose gain resets to zero.
  logic                  unipolar;
  logic [W-1:0]          self_gain_eff;
  logic [W:0]            raw_signed;
  logic signed [2*W+1:0] self_prod;
  logic [W+1:0]          self_scaled;
  logic [W+1:0]          s1_d;
  logic [W+1:0]          s1_q;
  logic                  s1_valid_q;
  logic [2:0]            s1_dest_q;
  logic                  s1_uni_q;

  // Offset binary only when both unipolar and offset format are chosen.
  // The choice travels with each result, so that a format change while
  // results are in flight cannot clamp one to the wrong range.
  assign unipolar = unipolar_bipolar_select && output_format_select;
  assign self_gain_eff = (self_gain_value_q == '0) ?
                         {1'b1, {(W-1){1'b0}}} : self_gain_value_q;
  assign raw_signed = unipolar ? {1'b0, raw_value}
                               : {raw_value[W-1], raw_value};
  // Both operands are widened to the full product width before the
  // multiply; a product of operand width would lose the integer part.
  assign self_prod = $signed(raw_signed) *
                     $signed({1'b0, self_gain_eff});
  assign self_scaled = self_prod[acc_pkg::GAIN_FRAC +: W+2];
  // Offset subtraction after self gain.
  assign s1_d = self_scaled - {{2{self_cal_offset_value_q[W-1]}},
                               self_cal_offset_value_q}; // RULE10 RULE11

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_valid_q <= 1'b0;
      s1_q       <= '0;
      s1_dest_q  <= 3'h0;
      s1_uni_q   <= 1'b0;
    end else begin
      s1_valid_q <= raw_valid;
      if (raw_valid) begin
        s1_q      <= s1_d;
        s1_dest_q <= raw_dest;
        s1_uni_q  <= unipolar;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stage 2: system offset of the selected set.

  logic [1:0]   sel_code;
  logic         use_a;
  logic         use_b;
  logic [W-1:0] sys_off;
  logic [W+1:0] s2_d;
  logic [W:0]   s2_q;
  logic         s2_valid_q;
  logic         s2_bypass_q;
  logic [2:0]   s2_dest_q;
  logic         s2_use_b_q;
  logic         s2_uni_q;

  assign sel_code = correction_set_select_q[s1_dest_q*2 +: 2];
  assign use_a = sel_code == acc_pkg::SEL_SET_A; // RULE13
  assign use_b = sel_code == acc_pkg::SEL_SET_B; // RULE13
  // Offset is sign-extended whatever the output format.
  assign sys_off = use_b ? system_offset_second_q // RULE1
                         : system_offset_first_q; // RULE14
  assign s2_d = (use_a || use_b) ?
                s1_q - {{2{sys_off[W-1]}}, sys_off} : s1_q; // RULE2 RULE4

  always_ff @(posedge clk) begin
    if (rst) begin
      s2_valid_q  <= 1'b0;
      s2_q        <= '0;
      s2_bypass_q <= 1'b0;
      s2_dest_q   <= 3'h0;
      s2_use_b_q  <= 1'b0;
      s2_uni_q    <= 1'b0;
    end else begin
      s2_valid_q <= s1_valid_q;
      if (s1_valid_q) begin
        // One guard bit is enough: stage 2 clamps coarse overflow here.
        if (s2_d[W+1] != s2_d[W]) begin
          s2_q <= {s2_d[W+1], {W{~s2_d[W+1]}}};
        end else begin
          s2_q <= s2_d[W:0];
        end
        s2_bypass_q <= !(use_a || use_b); // RULE16
        s2_dest_q   <= s1_dest_q;
        s2_use_b_q  <= use_b;
        s2_uni_q    <= s1_uni_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stage 3: system gain and saturation to the output range.

  logic [2:0]   s3_dest_q;
  logic [W-1:0] sys_gain;

  // Gain coefficients are read at this stage, so a rewrite reaches results
  // already past the offset stage: hold results back while recalibrating.
  assign sys_gain = s2_use_b_q ? system_gain_second_q
                               : system_gain_first_q; // RULE5 RULE6 RULE8

  acc_gain_mul #(
    .W (W)
  ) u_gain (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (s2_valid_q),
    .in_value  (s2_q),
    .gain      (sys_gain), // RULE5 RULE6 RULE8
    .bypass    (s2_bypass_q), // RULE16
    .unipolar  (s2_uni_q), // RULE15
    .out_valid (result_valid),
    .out_value (result_value)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      s3_dest_q <= 3'h0;
    end else if (s2_valid_q) begin
      s3_dest_q <= s2_dest_q;
    end
  end

  assign result_dest = s3_dest_q;

endmodule
`default_nettype wire

/* verification/acc_correct_asserts.sv */
/*
  Checker for the correction stage: register port timing, calibration
  loads and result stream. Assumes it is bound to acc_correct.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_checker #(
  parameter int unsigned W = 24
) (
  input wire logic         clk,
  input wire logic         rst,
  input wire logic [7:0]   reg_addr,
  input wire logic [31:0]  reg_wdata,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [31:0]  reg_rdata,
  input wire logic         raw_valid,
  input wire logic [2:0]   raw_dest,
  input wire logic         cal_load,
  input wire logic [2:0]   cal_target,
  input wire logic [W-1:0] cal_value,
  input wire logic         result_valid,
  input wire logic [W-1:0] result_value,
  input wire logic [2:0]   result_dest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_upper_zero: assert property (reg_rdata[31:24] == 8'h00)
    else $error("read data upper byte not zero");
  a_unmapped_zero: assert property (reg_rd && !(reg_addr inside
    {[8'h12:8'h18]}) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_write_readback: assert property (
    reg_wr && reg_addr inside {[8'h13:8'h17]} ##1
    reg_rd && reg_addr == $past(reg_addr)
    |-> ##1 reg_rdata == ($past(reg_wdata, 2) & 32'h00ffffff))
    else $error("coefficient not held as written");
  a_cal_readback: assert property (
    cal_load && !reg_wr && cal_target == 3'd2 ##2
    reg_rd && reg_addr == acc_pkg::OFF_SYS_OFF_B && !$past(reg_wr) &&
    !$past(cal_load) |-> ##1 reg_rdata == {8'h00, $past(cal_value, 3)})
    else $error("calibration value not stored");
  ////////////////////////////////////////////////////////////////////////
  a_result_latency: assert property (raw_valid |-> ##3 result_valid)
    else $error("result missing three cycles after input");
  a_result_origin: assert property (result_valid |-> $past(raw_valid, 3))
    else $error("result without input");
  a_dest_match: assert property (
    result_valid |-> result_dest == $past(raw_dest, 3))
    else $error("result destination mismatch");
  a_value_hold: assert property (!result_valid |->
    $stable(result_value) && $stable(result_dest))
    else $error("result changed between results");
endmodule
bind acc_correct acc_checker #(.W(W)) u_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_valid(raw_valid),
  .raw_dest(raw_dest), .cal_load(cal_load), .cal_target(cal_target),
  .cal_value(cal_value), .result_valid(result_valid),
  .result_value(result_value), .result_dest(result_dest));
`default_nettype wire

/* verification/acc_adc_source.sv */
/*
  Model of the conversion pipeline: raw results and calibration loads.
  Assumes the caller invokes its tasks from one process.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_adc_source (
  input  wire logic  clk,
  output logic       raw_valid,
  output logic [23:0] raw_value,
  output logic [2:0]  raw_dest,
  output logic        cal_load,
  output logic [2:0]  cal_target,
  output logic [23:0] cal_value
);
  initial begin
    raw_valid = 1'b0;
    raw_value = 24'h000000;
    raw_dest = 3'h0;
    cal_load = 1'b0;
    cal_target = 3'h0;
    cal_value = 24'h000000;
  end
  task automatic send(input logic [2:0] d, input logic [23:0] v);
    @(posedge clk);
    raw_valid <= 1'b1;
    raw_dest <= d;
    raw_value <= v;
  endtask
  // Stale data is inverted so that a late sample cannot pass by luck.
  task automatic idle();
    @(posedge clk);
    raw_valid <= 1'b0;
    raw_value <= ~raw_value;
  endtask
  task automatic cal(input logic [2:0] t, input logic [23:0] v);
    @(posedge clk);
    cal_load <= 1'b1;
    cal_target <= t;
    cal_value <= v;
    @(posedge clk);
    cal_load <= 1'b0;
    cal_value <= ~v;
  endtask
endmodule
`default_nettype wire

/* verification/adc_calibration_correction_bench.sv */
/*
  Self-checking bench for the correction stage.
  Assumes acc_correct, the pipeline model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_correction_bench;
  logic        clk, rst, reg_wr, reg_rd, raw_valid, cal_load, result_valid;
  logic        unipolar_bipolar_select, output_format_select;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [23:0] raw_value, cal_value, result_value;
  logic [2:0]  raw_dest, cal_target, result_dest;
  int          bad_count, cmp_count;
  logic [26:0] eq[$], rq[$];
  logic [23:0] coef[5];
  logic [23:0] sgain = 24'h800000;
  logic [7:0]  adr[5] = '{8'h17, 8'h13, 8'h14, 8'h15, 8'h16};
  logic [23:0] set0[5] = '{24'h10, 24'h100, 24'hffff00, 24'hc00000,
                           24'hffffff};
  logic [23:0] set1[5] = '{24'h20, 24'h200, 24'hfff000, 24'h400000,
                           24'hfffffe};
  logic [23:0] raws[5] = '{24'h001000, 24'h7f0000, 24'h900000,
                           24'hfffff0, 24'h800000};
  acc_correct uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .output_format_select(output_format_select),
    .unipolar_bipolar_select(unipolar_bipolar_select),
    .raw_valid(raw_valid), .raw_value(raw_value), .raw_dest(raw_dest),
    .cal_load(cal_load), .cal_target(cal_target), .cal_value(cal_value),
    .result_valid(result_valid), .result_value(result_value),
    .result_dest(result_dest));
  acc_adc_source src (.clk(clk), .raw_valid(raw_valid),
    .raw_value(raw_value), .raw_dest(raw_dest), .cal_load(cal_load),
    .cal_target(cal_target), .cal_value(cal_value));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (result_valid === 1'b1)
    rq.push_back({result_dest, result_value});
  task automatic give_verdict();
    $display("mismatches %0d of %0d compares", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_res(input logic [26:0] e, input logic [26:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk_reg(e, reg_rdata);
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] e);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk_reg(e, reg_rdata);
  endtask
  function automatic logic signed [63:0] sat(input logic signed [63:0] v);
    if (v > 64'sd8388607) return 64'sd8388607;
    if (v < -64'sd8388608) return -64'sd8388608;
    return v;
  endfunction
  // Two's complement reference: both gain products floor like a right
  // shift, and the offset-corrected value is clamped to 25 bits.
  function automatic logic [23:0] model(input logic [23:0] raw,
                                        input logic [1:0] sel);
    logic signed [63:0] s;
    s = $signed(raw);
    s = ((s * $signed({1'b0, sgain})) >>> 23) - $signed(coef[0]);
    if (sel < 2'd2) begin
      s = s - $signed(coef[1 + sel[0]]);
      if (s > 64'sd16777215) s = 64'sd16777215;
      if (s < -64'sd16777216) s = -64'sd16777216;
      s = (s * $signed({1'b0, coef[3 + sel[0]]})) >>> 23;
    end
    s = sat(s);
    return s[23:0];
  endfunction
  task automatic round(input logic [23:0] raw);
    for (int d = 0; d < 4; d++) begin
      src.send(d[2:0], raw);
      eq.push_back({d[2:0], model(raw, d[1:0])});
    end
  endtask
  task automatic drain();
    src.idle();
    repeat (5) @(posedge clk);
    #1 chk_reg(32'(eq.size()), 32'(rq.size()));
    while (eq.size() > 0 && rq.size() > 0)
      chk_res(eq.pop_front(), rq.pop_front());
    eq.delete();
    rq.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    rst = 1'b1;
    {unipolar_bipolar_select, output_format_select} = 2'b00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'h12; a < 8'h19; a++) rd_chk(a[7:0], 32'h0);
    wr_chk(8'h40, 32'hffffffff, 32'h0);
    wr_chk(acc_pkg::OFF_SEL, 32'hffff00e4, 32'he4);
    for (int t = 0; t < 5; t++) begin
      wr_chk(adr[t], {8'hff, set0[t]}, {8'h00, set0[t]});
      coef[t] = set0[t];
    end
    // Either format control alone must not change the two's complement arithmetic.
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      {unipolar_bipolar_select, output_format_select} <= m[1:0];
      foreach (raws[i]) round(raws[i]);
      drain();
    end
    for (int t = 0; t < 5; t++) begin
      src.cal(t[2:0], set1[t]);
      rd_chk(adr[t], {8'h00, set1[t]});
      coef[t] = set1[t];
    end
    round(24'h123456);
    round(24'hf00000);
    drain();
    @(posedge clk);
    {unipolar_bipolar_select, output_format_select} <= 2'b11;
    src.send(3'd2, 24'h000000);
    src.send(3'd1, 24'hffffff);
    eq.push_back({3'd2, 24'h000000});
    eq.push_back({3'd1, 24'hffffff});
    drain();
    // A non-unity self gain must act before the self offset.
    @(posedge clk);
    {unipolar_bipolar_select, output_format_select} <= 2'b00;
    wr_chk(acc_pkg::OFF_SELF_GAIN, 32'h00600000, 32'h00600000);
    sgain = 24'h600000;
    round(24'h123456);
    round(24'h900000);
    drain();
    give_verdict();
  end
endmodule
`default_nettype wire
